// *** cpu_memory_map_and_vectors.sv ***
`timescale 1ns/10ps
// How it works
// - Bottom 64 bytes hold reset and interrupt start addresses.
// - Vector low byte sits at even address, high byte at next odd one.
// - All four reset sources use the vector at address zero.
// - Second serial and second capture vectors exist only on larger parts.
// - Table call takes its entry address from the 64 bytes above vectors.
// - Five option bytes read low; boot swap also maps the upper copy.
// - Short call reaches any entry inside the dedicated entry area.
// - Debug part has ten security ID bytes above options, copied with swap.
// - Banked parts map the 16 KB window onto four or six flash banks.
// - Instruction straddling common area and window works only with bank 0.
// - Fast RAM ends below special registers; 1024 bytes, 768 on smallest.
// - Top 32 fast RAM bytes are four register banks, not executable.
// - Stack lives in fast RAM, never in expansion RAM.
// - Expansion RAM below fast RAM serves as data and program memory.
// - Peripheral registers decode in the top 256 bytes.
// - Program counter advances by instruction length, loads on branch.
// - Reset loads program counter from the two reset vector bytes.
// - Status byte pushed on interrupt or push, popped on return or pop.
// - Reset sets the status byte to its documented value.
// - Interrupt enable clears on acknowledge or disable, sets on enable.
// - Stack pointer decrements before a write, increments after a read.
module cpu_memory_map_and_vectors (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// reset sources
	input wire logic rst_ext,
	input wire logic power_on_clear,
	input wire logic low_voltage_detect,
	input wire logic watchdog_timeout,
	// fetch sequencing from the core
	input wire logic fetch_adv,
	input wire logic [2:0] fetch_len,
	input wire logic branch_load,
	input wire logic [15:0] branch_target,
	input wire logic one_byte_table_call,
	input wire logic [4:0] one_byte_table_call_index,
	input wire logic two_byte_short_call,
	input wire logic [10:0] two_byte_short_call_offset,
	// interrupt and status control
	input wire logic irq_ack,
	input wire logic [4:0] irq_slot,
	input wire logic software_break_trap,
	input wire logic ei_exec,
	input wire logic di_exec,
	input wire logic status_push_req,
	input wire logic return_from_interrupt,
	input wire logic return_from_break,
	input wire logic status_pop_req,
	// table read port
	output logic [15:0] mem_addr,
	output logic mem_rd,
	input wire logic [7:0] mem_rdata,
	// stack port
	output logic [15:0] stk_addr,
	output logic stk_wr,
	output logic [7:0] stk_wdata,
	output logic stk_rd,
	input wire logic [7:0] stk_rdata,
	// core state and address decode
	output logic [15:0] program_counter,
	output logic [7:0] processor_status_byte,
	output logic [15:0] stack_pointer,
	output logic busy,
	input wire logic [15:0] access_addr,
	output mmap_pkg::region_t fetch_region,
	output logic [16:0] fetch_flash_addr,
	output mmap_pkg::region_t access_region,
	output logic [16:0] access_flash_addr
);
	import mmap_pkg::*;

	seq_t state;
	logic [7:0] lo_byte;
	logic [2:0] bank_sel;
	logic [3:0] cfg;
	logic [FAULT_BITS-1:0] fault;
	logic [FAULT_BITS-1:0] fault_set;
	logic pop_pend;
	variant_t variant;
	logic reset_any;
	logic idle;
	logic run_ok;
	logic [15:0] vec_irq;
	logic [15:0] vec_one_byte_table_call;
	logic slot_unused;
	logic irq_take;
	logic brk_take;
	logic one_byte_table_call_take;
	logic table_start;
	logic [15:0] table_addr;
	logic two_byte_short_call_take;
	logic branch_take;
	logic fetch_take;
	logic push_take;
	logic pop_take;
	logic [15:0] sp_dec;
	logic [16:0] fetch_end;
	logic [15:0] dec_addr [2];
	region_t dec_region [2];
	logic [16:0] dec_flash [2];
	logic dec_exec [2];

	// ----------------------------------------------------------------
	// request arbitration
	// ----------------------------------------------------------------
	assign variant = variant_t'(cfg[2:0]);
	assign reset_any = rst_ext | power_on_clear | low_voltage_detect | watchdog_timeout;
	assign idle = state == ST_IDLE;
	assign vec_irq = {10'h000, irq_slot, 1'b0};
	assign vec_one_byte_table_call = ONE_BYTE_TABLE_CALL_LO + {10'h000, one_byte_table_call_index, 1'b0};
	assign slot_unused = vec_irq >= LARGE_VEC_FIRST && vec_irq <= LARGE_VEC_LAST
		&& variant < VAR_48K;
	assign irq_take = !reset_any && idle && irq_ack && !slot_unused;
	assign brk_take = !reset_any && idle && !irq_ack && software_break_trap;
	assign one_byte_table_call_take = !reset_any && idle && !irq_ack && !software_break_trap
		&& one_byte_table_call;
	assign table_start = irq_take | brk_take | one_byte_table_call_take;
	assign table_addr = irq_take ? vec_irq : (brk_take ? BRK_VECTOR : vec_one_byte_table_call);
	assign run_ok = !reset_any && idle && !irq_ack && !software_break_trap
		&& !one_byte_table_call;
	assign two_byte_short_call_take = run_ok && two_byte_short_call;
	assign branch_take = run_ok && !two_byte_short_call && branch_load;
	assign fetch_take = run_ok && !two_byte_short_call && !branch_load && fetch_adv;
	assign push_take = !reset_any && (irq_take | brk_take | status_push_req);
	assign pop_take = !reset_any && !push_take
		&& (return_from_interrupt | return_from_break | status_pop_req);
	assign sp_dec = stack_pointer - 16'h0001;
	assign fetch_end = {1'b0, program_counter} + {14'h0000, fetch_len};
	assign busy = !idle;

	// ----------------------------------------------------------------
	// address decoders for fetch and data access
	// ----------------------------------------------------------------
	assign dec_addr[0] = program_counter;
	assign dec_addr[1] = access_addr;
	generate
		for (genvar i = 0; i < 2; i++) begin : g_dec
			mmap_if bus ();
			assign bus.addr = dec_addr[i];
			assign bus.bank = bank_sel;
			assign bus.variant = variant;
			assign bus.boot_swap = cfg[CFG_SWAP_BIT];
			assign dec_region[i] = bus.region;
			assign dec_flash[i] = bus.flash_addr;
			assign dec_exec[i] = bus.exec_ok;
			mmap_decode u_decode (
				.bus(bus.decoder)
			);
		end
	endgenerate
	assign fetch_region = dec_region[0];
	assign fetch_flash_addr = dec_flash[0];
	assign access_region = dec_region[1];
	assign access_flash_addr = dec_flash[1];

	// ----------------------------------------------------------------
	// vector and table read sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_LO;
			mem_rd <= 1'b1;
			mem_addr <= RESET_VECTOR;
			lo_byte <= 8'h00;
		end else if (reset_any) begin
			state <= ST_LO;
			mem_rd <= 1'b1;
			mem_addr <= RESET_VECTOR;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (table_start) begin
						state <= ST_LO;
						mem_rd <= 1'b1;
						mem_addr <= table_addr;
					end
				end
				ST_LO: begin
					state <= ST_HI;
					mem_addr <= mem_addr + 16'h0001;
				end
				ST_HI: begin
					state <= ST_LOAD;
					mem_rd <= 1'b0;
					lo_byte <= mem_rdata;
				end
				ST_LOAD: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// program counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			program_counter <= RESET_VECTOR;
		end else if (state == ST_LOAD) begin
			program_counter <= {mem_rdata, lo_byte};
		end else if (reg_wr && reg_addr == REG_PC_LO) begin
			program_counter[7:0] <= reg_wdata;
		end else if (reg_wr && reg_addr == REG_PC_HI) begin
			program_counter[15:8] <= reg_wdata;
		end else if (two_byte_short_call_take) begin
			program_counter <= TWO_BYTE_SHORT_CALL_LO | {5'h00, two_byte_short_call_offset};
		end else if (branch_take) begin
			program_counter <= branch_target;
		end else if (fetch_take) begin
			program_counter <= fetch_end[15:0];
		end
	end

	// ----------------------------------------------------------------
	// status byte, stack pointer and stack port
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			processor_status_byte <= STATUS_RESET;
		end else if (reset_any) begin
			processor_status_byte <= STATUS_RESET;
		end else if (pop_pend) begin
			processor_status_byte <= stk_rdata;
		end else if (reg_wr && reg_addr == REG_STATUS) begin
			processor_status_byte <= reg_wdata;
		end else if (irq_take || di_exec) begin
			processor_status_byte[IE_BIT] <= 1'b0;
		end else if (ei_exec) begin
			processor_status_byte[IE_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stack_pointer <= SP_RESET;
		end else if (push_take) begin
			stack_pointer <= sp_dec;
		end else if (pop_take) begin
			stack_pointer <= stack_pointer + 16'h0001;
		end else if (reg_wr && reg_addr == REG_SP_LO) begin
			stack_pointer[7:0] <= reg_wdata;
		end else if (reg_wr && reg_addr == REG_SP_HI) begin
			stack_pointer[15:8] <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stk_wr <= 1'b0;
			stk_rd <= 1'b0;
			pop_pend <= 1'b0;
			stk_addr <= SP_RESET;
			stk_wdata <= 8'h00;
		end else begin
			stk_wr <= push_take;
			stk_rd <= pop_take;
			pop_pend <= stk_rd && !reset_any;
			stk_addr <= push_take ? sp_dec : stack_pointer;
			stk_wdata <= processor_status_byte;
		end
	end

	// ----------------------------------------------------------------
	// bank select, configuration, faults
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bank_sel <= 3'h0;
			cfg <= CONFIG_RESET;
		end else if (reg_wr) begin
			if (reg_addr == REG_BANK && reg_wdata[2:0] < bank_count(variant)) begin
				bank_sel <= reg_wdata[2:0];
			end
			if (reg_addr == REG_CONFIG) begin
				cfg <= reg_wdata[3:0];
			end
		end
	end

	always_comb begin
		fault_set = '0;
		fault_set[FLT_EXEC] = fetch_take && !dec_exec[0];
		fault_set[FLT_STRADDLE] = fetch_take && program_counter <= COMMON_HI
			&& fetch_end > {1'b0, BANK_LO} && bank_sel != 3'h0 && is_banked(variant);
		fault_set[FLT_STACK] = (push_take && !(sp_dec >= hs_ram_lo(variant) && sp_dec <= GREG_HI))
			|| (pop_take && !(stack_pointer >= hs_ram_lo(variant)
			&& stack_pointer <= GREG_HI));
		fault_set[FLT_VECTOR] = !reset_any && idle && irq_ack && slot_unused;
		fault_set[FLT_BANK] = reg_wr && reg_addr == REG_BANK
			&& reg_wdata[2:0] >= bank_count(variant);
	end

	// write one to clear, a new event in the same cycle wins
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			fault <= '0;
		end else begin
			fault <= (fault & ~((reg_wr && reg_addr == REG_FAULT) ? reg_wdata[FAULT_BITS-1:0]
				: '0)) | fault_set;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_PC_LO: reg_rdata <= program_counter[7:0];
				REG_PC_HI: reg_rdata <= program_counter[15:8];
				REG_STATUS: reg_rdata <= processor_status_byte;
				REG_BANK: reg_rdata <= {5'h00, bank_sel};
				REG_CONFIG: reg_rdata <= {4'h0, cfg};
				REG_SP_LO: reg_rdata <= stack_pointer[7:0];
				REG_SP_HI: reg_rdata <= stack_pointer[15:8];
				REG_FAULT: reg_rdata <= {3'h0, fault};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_pair;
		(state == ST_HI && mem_rd && mem_addr == $past(mem_addr) + 16'h0001) ##1 state == ST_LOAD;
	endsequence
	sequence s_pop;
		(stk_rd && stk_addr == $past(stack_pointer)
			&& stack_pointer == $past(stack_pointer) + 16'h0001) ##1 pop_pend;
	endsequence

	property p_vec_even;
		state == ST_LO |-> mem_rd && mem_addr[0] == 1'b0;
	endproperty
	a_vec_even: assert property (p_vec_even) else $error("table read starts on odd address");
	property p_vec_pair;
		disable iff (sys_rst || reset_any) state == ST_LO && !reset_any |=> s_pair;
	endproperty
	a_vec_pair: assert property (p_vec_pair) else $error("high byte read not after low");
	property p_pc_load;
		state == ST_LOAD |=> program_counter == {$past(mem_rdata), $past(lo_byte)};
	endproperty
	a_pc_load: assert property (p_pc_load) else $error("counter not loaded from vector");
	property p_reset_vec;
		reset_any |=> state == ST_LO && mem_addr == RESET_VECTOR
			&& processor_status_byte == STATUS_RESET;
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("reset source not at vector 0");
	property p_status_reset;
		$fell(sys_rst) |-> processor_status_byte == STATUS_RESET;
	endproperty
	a_status_reset: assert property (p_status_reset) else $error("status byte reset wrong");
	property p_irq_ie;
		irq_take && !pop_pend && !(reg_wr && reg_addr == REG_STATUS)
			|=> !processor_status_byte[IE_BIT] ##2 mem_addr[15:6] == 10'h000;
	endproperty
	a_irq_ie: assert property (p_irq_ie) else $error("enable flag kept on acknowledge");
	property p_push;
		push_take |=> stk_wr && stk_addr == stack_pointer
			&& stk_wdata == $past(processor_status_byte);
	endproperty
	a_push: assert property (p_push) else $error("push not pre-decremented");
	property p_pop;
		disable iff (sys_rst || reset_any) pop_take |-> ##1 s_pop;
	endproperty
	a_pop: assert property (p_pop) else $error("pop sequence wrong");
	property p_fetch;
		fetch_take && !reg_wr |=> program_counter == $past(program_counter)
			+ {13'h0000, $past(fetch_len)};
	endproperty
	a_fetch: assert property (p_fetch) else $error("counter did not advance by length");
	property p_two_byte_short_call;
		two_byte_short_call_take && !reg_wr |=> program_counter[15:11] == 5'h01;
	endproperty
	a_two_byte_short_call: assert property (p_two_byte_short_call) else $error("short call left entry area");
	property p_one_byte_table_call;
		one_byte_table_call_take |=> mem_addr == ONE_BYTE_TABLE_CALL_LO + {10'h000, $past(one_byte_table_call_index), 1'b0};
	endproperty
	a_one_byte_table_call: assert property (p_one_byte_table_call) else $error("table call read wrong slot");
	property p_unused_slot;
		idle && irq_ack && slot_unused && !reset_any |=> idle && fault[FLT_VECTOR];
	endproperty
	a_unused_slot: assert property (p_unused_slot) else $error("unused vector taken");
	property p_bank_route;
		fetch_region == RGN_FLASH_BANK |-> fetch_flash_addr[16:14] == bank_sel + 3'h2;
	endproperty
	a_bank_route: assert property (p_bank_route) else $error("window not on selected bank");
endmodule

// *** mmap_pkg.sv ***
package mmap_pkg;
	// ----------------------------------------------------------------
	// variants, regions, sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		VAR_16K = 3'h0, VAR_24K = 3'h1, VAR_32K = 3'h2, VAR_48K = 3'h3,
		VAR_60K = 3'h4, VAR_96K = 3'h5, VAR_128K = 3'h6, VAR_128K_DBG = 3'h7
	} variant_t;
	typedef enum logic [3:0] {
		RGN_VECTOR = 4'h0, RGN_ONE_BYTE_TABLE_CALL = 4'h1, RGN_OPTION = 4'h2, RGN_DEBUG_ID = 4'h3,
		RGN_TWO_BYTE_SHORT_CALL = 4'h4, RGN_FLASH_COMMON = 4'h5, RGN_FLASH_BANK = 4'h6,
		RGN_EXP_RAM = 4'h7, RGN_HS_RAM = 4'h8, RGN_GREG = 4'h9, RGN_SFR = 4'hA,
		RGN_RESERVED = 4'hB
	} region_t;
	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_LO = 2'h1, ST_HI = 2'h2, ST_LOAD = 2'h3} seq_t;

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam logic [15:0] VECTOR_HI = 16'h003F;
	localparam logic [15:0] ONE_BYTE_TABLE_CALL_LO = 16'h0040;
	localparam logic [15:0] ONE_BYTE_TABLE_CALL_HI = 16'h007F;
	localparam logic [15:0] OPTION_LO = 16'h0080;
	localparam logic [15:0] OPTION_HI = 16'h0084;
	localparam logic [15:0] DEBUG_ID_HI = 16'h008E;
	localparam logic [15:0] SWAP_OFFSET = 16'h1000;
	localparam logic [15:0] TWO_BYTE_SHORT_CALL_LO = 16'h0800;
	localparam logic [15:0] TWO_BYTE_SHORT_CALL_HI = 16'h0FFF;
	localparam logic [15:0] COMMON_HI = 16'h7FFF;
	localparam logic [15:0] BANK_LO = 16'h8000;
	localparam logic [15:0] BANK_HI = 16'hBFFF;
	localparam logic [15:0] EXP_RAM_HI = 16'hF7FF;
	localparam logic [15:0] EXP_RAM_NONE = 16'hF800;
	localparam logic [15:0] HS_RAM_LO = 16'hFB00;
	localparam logic [15:0] HS_RAM_LO_SMALL = 16'hFC00;
	localparam logic [15:0] GREG_LO = 16'hFEE0;
	localparam logic [15:0] GREG_HI = 16'hFEFF;
	localparam logic [15:0] SFR_LO = 16'hFF00;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [15:0] BRK_VECTOR = 16'h003E;
	localparam logic [15:0] LARGE_VEC_FIRST = 16'h0036;
	localparam logic [15:0] LARGE_VEC_LAST = 16'h003A;
	localparam logic [15:0] FLASH_TOP_16K = 16'h3FFF;
	localparam logic [15:0] FLASH_TOP_24K = 16'h5FFF;
	localparam logic [15:0] FLASH_TOP_48K = 16'hBFFF;
	localparam logic [15:0] FLASH_TOP_60K = 16'hEFFF;
	localparam logic [15:0] EXP_RAM_LO_48K = 16'hF400;
	localparam logic [15:0] EXP_RAM_LO_60K = 16'hF000;
	localparam logic [15:0] EXP_RAM_LO_96K = 16'hE800;
	localparam logic [15:0] EXP_RAM_LO_128K = 16'hE000;
	localparam logic [16:0] BANK_PHYS_BASE = 17'h08000;
	localparam logic [2:0] BANKS_NONE = 3'h1;
	localparam logic [2:0] BANKS_96K = 3'h4;
	localparam logic [2:0] BANKS_128K = 3'h6;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_PC_LO = 8'h00;
	localparam logic [7:0] REG_PC_HI = 8'h01;
	localparam logic [7:0] REG_STATUS = 8'h02;
	localparam logic [7:0] REG_BANK = 8'h03;
	localparam logic [7:0] REG_CONFIG = 8'h04;
	localparam logic [7:0] REG_SP_LO = 8'h05;
	localparam logic [7:0] REG_SP_HI = 8'h06;
	localparam logic [7:0] REG_FAULT = 8'h07;
	localparam logic [7:0] STATUS_RESET = 8'h02;
	localparam int IE_BIT = 7;
	localparam int CFG_SWAP_BIT = 3;
	localparam logic [3:0] CONFIG_RESET = 4'h6;
	localparam logic [15:0] SP_RESET = 16'hFEE0;
	localparam int FLT_EXEC = 0;
	localparam int FLT_STRADDLE = 1;
	localparam int FLT_STACK = 2;
	localparam int FLT_VECTOR = 3;
	localparam int FLT_BANK = 4;
	localparam int FAULT_BITS = 5;

	function automatic logic is_banked(input variant_t v);
		return v >= VAR_96K;
	endfunction
	function automatic logic [2:0] bank_count(input variant_t v);
		return (v == VAR_96K) ? BANKS_96K : (is_banked(v) ? BANKS_128K : BANKS_NONE);
	endfunction
	function automatic logic [15:0] hs_ram_lo(input variant_t v);
		return (v == VAR_16K) ? HS_RAM_LO_SMALL : HS_RAM_LO;
	endfunction
	function automatic logic [15:0] flash_top(input variant_t v);
		unique case (v)
			VAR_16K: return FLASH_TOP_16K;
			VAR_24K: return FLASH_TOP_24K;
			VAR_48K: return FLASH_TOP_48K;
			VAR_60K: return FLASH_TOP_60K;
			VAR_32K, VAR_96K, VAR_128K, VAR_128K_DBG: return COMMON_HI;
		endcase
	endfunction
	function automatic logic [15:0] exp_ram_lo(input variant_t v);
		unique case (v)
			VAR_16K, VAR_24K, VAR_32K: return EXP_RAM_NONE;
			VAR_48K: return EXP_RAM_LO_48K;
			VAR_60K: return EXP_RAM_LO_60K;
			VAR_96K: return EXP_RAM_LO_96K;
			VAR_128K, VAR_128K_DBG: return EXP_RAM_LO_128K;
		endcase
	endfunction
endpackage

// *** mmap_if.sv ***
`timescale 1ns/10ps
interface mmap_if;
	import mmap_pkg::*;
	logic [15:0] addr;
	logic [2:0] bank;
	variant_t variant;
	logic boot_swap;
	region_t region;
	logic [16:0] flash_addr;
	logic exec_ok;
	logic stack_ok;
	modport decoder(input addr, bank, variant, boot_swap, output region, flash_addr, exec_ok,
		stack_ok);
	modport core(output addr, bank, variant, boot_swap, input region, flash_addr, exec_ok,
		stack_ok);
endinterface

// *** mmap_decode.sv ***
`timescale 1ns/10ps
module mmap_decode (
	// address to classify
	mmap_if.decoder bus
);
	import mmap_pkg::*;
	logic banked;
	logic dbg;
	logic swap_hit;
	logic [15:0] rel;

	always_comb begin
		banked = is_banked(bus.variant);
		dbg = bus.variant == VAR_128K_DBG;
		rel = bus.addr - SWAP_OFFSET;
		swap_hit = bus.boot_swap && rel >= OPTION_LO && rel <= DEBUG_ID_HI;
		bus.flash_addr = {1'b0, bus.addr};
		if (bus.addr >= SFR_LO) begin
			bus.region = RGN_SFR;
		end else if (bus.addr >= GREG_LO) begin
			bus.region = RGN_GREG;
		end else if (bus.addr >= hs_ram_lo(bus.variant)) begin
			bus.region = RGN_HS_RAM;
		end else if (bus.addr >= exp_ram_lo(bus.variant) && bus.addr <= EXP_RAM_HI) begin
			bus.region = RGN_EXP_RAM;
		end else if (banked && bus.addr >= BANK_LO && bus.addr <= BANK_HI) begin
			// window offset lands in the selected bank's slice of flash
			bus.flash_addr = BANK_PHYS_BASE + {bus.bank, 14'h0000} + {3'h0, bus.addr[13:0]};
			bus.region = (bus.bank < bank_count(bus.variant)) ? RGN_FLASH_BANK : RGN_RESERVED;
		end else if (bus.addr <= flash_top(bus.variant)) begin
			if (bus.addr <= VECTOR_HI) begin
				bus.region = RGN_VECTOR;
			end else if (bus.addr <= ONE_BYTE_TABLE_CALL_HI) begin
				bus.region = RGN_ONE_BYTE_TABLE_CALL;
			end else if (bus.addr <= OPTION_HI) begin
				bus.region = RGN_OPTION;
			end else if (bus.addr <= DEBUG_ID_HI) begin
				bus.region = dbg ? RGN_DEBUG_ID : RGN_RESERVED;
			end else if (swap_hit) begin
				bus.region = (rel <= OPTION_HI) ? RGN_OPTION : (dbg ? RGN_DEBUG_ID : RGN_RESERVED);
			end else if (bus.addr >= TWO_BYTE_SHORT_CALL_LO && bus.addr <= TWO_BYTE_SHORT_CALL_HI) begin
				bus.region = RGN_TWO_BYTE_SHORT_CALL;
			end else begin
				bus.region = RGN_FLASH_COMMON;
			end
		end else begin
			bus.region = RGN_RESERVED;
		end
		bus.exec_ok = !(bus.region inside {RGN_GREG, RGN_SFR, RGN_RESERVED});
		bus.stack_ok = bus.region inside {RGN_HS_RAM, RGN_GREG};
	end
endmodule

// *** core_mem.sv ***
`timescale 1ns/10ps
module core_mem (
	// clock
	input wire logic clk_sys,
	// table and stack ports
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	output logic [7:0] mem_rdata = 8'h00,
	input wire logic stk_rd,
	output logic [7:0] stk_rdata = 8'h00
);
	// ----------------------------------------------------------------
	// byte answers one cycle after a read, inverted when not asked
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		mem_rdata <= mem_rd ? mem_addr[7:0] + 8'h11 : ~mem_rdata;
		stk_rdata <= stk_rd ? 8'h81 : ~stk_rdata;
	end
endmodule

// *** tb_top.sv ***
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
	$display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
	import mmap_pkg::*;
	logic clk_sys = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, busy, mem_rd, stk_wr, stk_rd;
	logic rst_ext = 1'h0, power_on_clear = 1'h0, low_voltage_detect = 1'h0;
	logic watchdog_timeout = 1'h0, fetch_adv = 1'h0, branch_load = 1'h0, one_byte_table_call = 1'h0;
	logic two_byte_short_call = 1'h0, irq_ack = 1'h0, software_break_trap = 1'h0, ei_exec = 1'h0;
	logic di_exec = 1'h0, status_push_req = 1'h0, return_from_interrupt = 1'h0;
	logic return_from_break = 1'h0, status_pop_req = 1'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, mem_rdata, stk_rdata, stk_wdata;
	logic [7:0] processor_status_byte;
	logic [2:0] fetch_len = 3'h0;
	logic [4:0] one_byte_table_call_index = 5'h00, irq_slot = 5'h00;
	logic [10:0] two_byte_short_call_offset = 11'h000;
	logic [15:0] branch_target = 16'h0000, access_addr = 16'h0000, mem_addr, stk_addr;
	logic [15:0] program_counter, stack_pointer;
	logic [16:0] fetch_flash_addr, access_flash_addr;
	region_t fetch_region, access_region;
	int err_total = 0, comparisons = 0, cycles = 0;
	cpu_memory_map_and_vectors dut (.*);
	core_mem mem (.*);
	// ----------------------------------------------------------------
	// clock, timeout, helpers
	// ----------------------------------------------------------------
	initial forever #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (++cycles == 3000) begin
		err_total++;
		stop_test();
	end
	function automatic logic [15:0] vec(input logic [15:0] a);
		return {a[7:0] + 8'h12, a[7:0] + 8'h11};
	endfunction
	task step;
		@(posedge clk_sys);
		#1;
	endtask
	task settle;
		for (int i = 0; i < 8 && busy !== 1'h0; i++) step();
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'h1;
		step();
		reg_rd <= 1'h0;
		`CHK(reg_rdata, e)
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		step();
		reg_wr <= 1'h0;
	endtask
	task stop_test;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset;
		for (int i = 0; i < 4; i++) begin
			wr(REG_STATUS, 8'hA5);
			branch_load <= 1'h1;
			branch_target <= 16'h1234;
			step();
			branch_load <= 1'h0;
			`CHK(program_counter, 16'h1234)
			{rst_ext, power_on_clear, low_voltage_detect, watchdog_timeout} <= 4'h1 << i;
			step();
			{rst_ext, power_on_clear, low_voltage_detect, watchdog_timeout} <= 4'h0;
			settle();
			`CHK(program_counter, vec(RESET_VECTOR))
			rd(REG_STATUS, STATUS_RESET);
		end
	endtask
	task t_irq;
		ei_exec <= 1'h1;
		step();
		ei_exec <= 1'h0;
		irq_ack <= 1'h1;
		irq_slot <= 5'h04;
		step();
		irq_ack <= 1'h0;
		`CHK({stk_wr, stk_wdata, stk_addr}, {1'h1, 8'h82, SP_RESET - 16'h1})
		`CHK(processor_status_byte[IE_BIT], 1'h0)
		`CHK({mem_rd, mem_addr}, {1'h1, 16'h0008})
		settle();
		`CHK(program_counter, vec(16'h0008))
		return_from_interrupt <= 1'h1;
		step();
		return_from_interrupt <= 1'h0;
		`CHK({stk_rd, stk_addr, stack_pointer}, {1'h1, SP_RESET - 16'h1, SP_RESET})
		step();
		step();
		`CHK(processor_status_byte, 8'h81)
	endtask
	task t_brk;
		software_break_trap <= 1'h1;
		step();
		software_break_trap <= 1'h0;
		`CHK({stk_wr, stk_wdata, processor_status_byte}, {1'h1, 8'h81, 8'h81})
		settle();
		`CHK(program_counter, vec(BRK_VECTOR))
		{di_exec, return_from_break, status_pop_req} <= 3'h7;
		step();
		{di_exec, return_from_break, status_pop_req} <= 3'h0;
		`CHK({stk_rd, processor_status_byte}, {1'h1, 8'h01})
		step();
		step();
		`CHK({stack_pointer, processor_status_byte}, {SP_RESET, 8'h81})
		status_push_req <= 1'h1;
		step();
		status_push_req <= 1'h0;
		`CHK({stk_wr, stk_wdata, stack_pointer}, {1'h1, 8'h81, SP_RESET - 16'h1})
	endtask
	task t_slot;
		wr(REG_CONFIG, 8'h00);
		irq_ack <= 1'h1;
		irq_slot <= 5'h1B;
		step();
		irq_ack <= 1'h0;
		`CHK(busy, 1'h0)
		rd(REG_FAULT, 8'h08);
		wr(REG_CONFIG, 8'h06);
	endtask
	task t_call;
		one_byte_table_call <= 1'h1;
		one_byte_table_call_index <= 5'h1F;
		step();
		one_byte_table_call <= 1'h0;
		settle();
		`CHK(program_counter, vec(ONE_BYTE_TABLE_CALL_HI - 16'h1))
		two_byte_short_call <= 1'h1;
		two_byte_short_call_offset <= 11'h7FF;
		step();
		two_byte_short_call <= 1'h0;
		`CHK({fetch_region, fetch_flash_addr}, {RGN_TWO_BYTE_SHORT_CALL, 17'h00FFF})
		fetch_adv <= 1'h1;
		fetch_len <= 3'h3;
		step();
		fetch_adv <= 1'h0;
		`CHK(program_counter, TWO_BYTE_SHORT_CALL_HI + 16'h3)
	endtask
	task t_map;
		wr(REG_BANK, 8'h05);
		access_addr <= BANK_HI;
		step();
		`CHK({access_region, access_flash_addr}, {RGN_FLASH_BANK, 17'h1FFFF})
		access_addr <= 16'hFF00;
		step();
		`CHK(access_region, RGN_SFR)
		access_addr <= GREG_LO;
		step();
		`CHK(access_region, RGN_GREG)
		access_addr <= EXP_RAM_LO_128K;
		step();
		`CHK(access_region, RGN_EXP_RAM)
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'h0;
		settle();
		t_reset();
		t_irq();
		t_call();
		t_map();
		t_slot();
		t_brk();
		stop_test();
	end
endmodule
